/* File: pkg/tfs_pkg.sv */
// Package: register map, field positions and reset values of the FIFO status block
package tfs_pkg;
  localparam logic [7:0] TFS_ADDR_AUX_IRQ    = 8'h0B;
  localparam logic [7:0] TFS_ADDR_FIFO_CNT   = 8'h0C;
  localparam logic [7:0] TFS_ADDR_FIFO_ERR   = 8'h0D;
  localparam logic [7:0] TFS_ADDR_TX_LEN_HI  = 8'h10;
  localparam logic [7:0] TFS_ADDR_TX_LEN_LO  = 8'h11;
  localparam logic [7:0] TFS_RST_REG         = 8'h00;
  localparam logic [5:0] TFS_FIFO_DEPTH      = 6'h20;
  localparam logic [5:0] TFS_CNT_ZERO        = 6'h00;
  localparam int         TFS_BIT_UNF         = 6;
  localparam int         TFS_BIT_OVR         = 5;
  localparam int         TFS_BIT_NCP         = 4;
  localparam int         TFS_BIT_NPAR        = 0;
  localparam int         TFS_BIT_AUX_FR      = 6;
  localparam int         TFS_BIT_AUX_FIFO    = 3;
  localparam logic [2:0] TFS_SPLIT_NONE      = 3'h0;
endpackage

/* File: src/tfs_top.sv */
// FIFO status, transmit length and auxiliary interrupt registers
// Function
// - Reading the auxiliary interrupt register clears it; flags set in the read cycle stay set.
// - Auxiliary interrupt register is zero after reset and restore-defaults.
// - First status register gives unread byte count in bits 5..0.
// - Unread count stays between 0 and 32; zero means nothing to read.
// - Both status registers clear on reset, restore-defaults and FIFO clear, except an error flag whose fault comes in the clear cycle.
// - Bit 6 flags underflow on over-read; bit 5 flags overflow.
// - Incomplete last byte sets bit 4, valid bit count in bits 3..1.
// - Missing parity on last byte sets bit 0, also a framing error.
// - Ten-bit full byte count split: high five at 10h, low five at 11h.
// - Transmit count fields clear on reset and restore-defaults.
// - Bits 2..0 at 11h give split byte bits; zero means all full.
// - Split bits used only in level-3 mode with bit-stream transmit set.
// - FIFO overflow or underflow raises FIFO error in auxiliary register.

// Working notes for whoever picks this block up next:
// The register port is on the logic clock, so no input is resynchronised.
// Reads have one side effect only: the auxiliary register clears when read.
// Reads of the FIFO status registers never disturb the counter or flags.
// The unread counter follows push and pop pulses from the data path.
// A pop from an empty FIFO is an underflow and leaves the count at zero.
// A push into a full FIFO is an overflow and leaves the count at 32.
// A push and a pop in the same cycle cancel, also when the FIFO is empty.
// Underflow and overflow are sticky until restore-defaults or FIFO clear.
// A fault in the cycle of a clear command survives that command.
// The last-byte fields describe the newest pushed byte, not the oldest.
// The transmit length is stored as ten bits; reserved bits are never kept.
// The framer sees the length one cycle after the register changes.
// The split-byte bits reach the framer only in level-3 bit-stream mode,
// so a stale split count cannot truncate a normal framed transmission.
// Unmapped addresses read as zero and take no writes.
// FIFO clear leaves the auxiliary register alone; restore-defaults clears
// it, because the host may still owe a read of a pending FIFO error.
module tfs_top
  import tfs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Register port from the serial interface, same clock
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_q,
  // Direct commands, one-cycle pulses
  input  wire logic       cmd_set_default,
  input  wire logic       cmd_fifo_clear,
  // FIFO events from the data path
  input  wire logic       fifo_push,
  input  wire logic       fifo_pop,
  input  wire logic       rx_last_partial,
  input  wire logic [2:0] rx_last_bits,
  input  wire logic       rx_parity_missing,
  input  wire logic       aux_other_set_en,
  input  wire logic [7:0] aux_other_set,
  // Framing configuration
  input  wire logic       level3_mode,
  input  wire logic       bit_stream_tx,
  // Transmit length towards the framer
  output logic      [9:0] tx_bytes_q,
  output logic      [2:0] tx_split_bits_q
);

  // FIFO occupancy and sticky error state
  logic [5:0] unread_q;
  logic       unf_q;
  logic       ovr_q;
  // Description of the newest byte pushed, including one dropped on overflow
  logic       ncp_q;
  logic [2:0] lbits_q;
  logic       npar_q;
  // Auxiliary interrupt flags and their set vector for this cycle
  logic [7:0] aux_q;
  logic [7:0] aux_set;
  logic       aux_read;
  // Host programmed transmit length
  logic [9:0] ntx_q;
  logic [2:0] nbtx_q;
  // Occupancy events, decoded once and shared by counter and flags
  logic       fifo_rst;
  logic       rd_cnt;
  logic       underflow;
  logic       overflow;
  logic       fifo_pop_eff;
  logic       cnt_up;
  logic       cnt_down;

  // Either command empties the FIFO; only restore-defaults touches the rest
  assign fifo_rst     = cmd_set_default | cmd_fifo_clear;
  // Host reads of the data register pop; a read from empty is an underflow
  assign rd_cnt       = fifo_pop;
  assign underflow    = rd_cnt && (unread_q == TFS_CNT_ZERO) && !fifo_push;
  assign overflow     = fifo_push && !rd_cnt && (unread_q == TFS_FIFO_DEPTH);
  assign fifo_pop_eff = rd_cnt && !underflow;
  // Push with pop cancels, even when empty: the byte passes straight through
  assign cnt_up       = fifo_push && !fifo_pop_eff && !overflow;
  assign cnt_down     = fifo_pop_eff && !fifo_push;
  // Read of the auxiliary register, the only read with a side effect
  assign aux_read     = reg_rd && (reg_addr == TFS_ADDR_AUX_IRQ);

  // Unread byte counter; faults freeze it, so it stays in 0..32 unclamped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      unread_q <= TFS_CNT_ZERO;
    end else if (fifo_rst) begin
      unread_q <= TFS_CNT_ZERO;
    end else if (cnt_up) begin
      unread_q <= unread_q + 6'h01;
    end else if (cnt_down) begin
      unread_q <= unread_q - 6'h01;
    end
  end

  // Sticky error flags; a fault racing a clear command wins, never lost
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      unf_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      if (underflow) begin
        unf_q <= 1'b1;
      end else if (fifo_rst) begin
        unf_q <= 1'b0;
      end
      if (overflow) begin
        ovr_q <= 1'b1;
      end else if (fifo_rst) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // Last received byte description, refreshed with each pushed byte
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ncp_q   <= 1'b0;
      lbits_q <= 3'h0;
      npar_q  <= 1'b0;
    end else if (fifo_rst) begin
      ncp_q   <= 1'b0;
      lbits_q <= 3'h0;
      npar_q  <= 1'b0;
    end else if (fifo_push) begin
      ncp_q   <= rx_last_partial;
      lbits_q <= rx_last_partial ? rx_last_bits : 3'h0;
      npar_q  <= rx_parity_missing;
    end
  end

  // Set vector: other sources, FIFO fault and framing error of a pushed byte
  always_comb begin
    aux_set = aux_other_set_en ? aux_other_set : TFS_RST_REG;
    aux_set[TFS_BIT_AUX_FIFO] = aux_set[TFS_BIT_AUX_FIFO] | underflow | overflow;
    aux_set[TFS_BIT_AUX_FR] = aux_set[TFS_BIT_AUX_FR] | (fifo_push & rx_parity_missing);
  end

  // Auxiliary interrupt: the read clears, but a set in the read cycle
  // survives so the host meets it on its next read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      aux_q <= TFS_RST_REG;
    end else if (cmd_set_default) begin
      aux_q <= TFS_RST_REG;
    end else if (aux_read) begin
      aux_q <= aux_set;
    end else begin
      aux_q <= aux_q | aux_set;
    end
  end

  // Transmit length registers; reserved bits are not stored
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ntx_q  <= 10'h000;
      nbtx_q <= TFS_SPLIT_NONE;
    end else if (cmd_set_default) begin
      ntx_q  <= 10'h000;
      nbtx_q <= TFS_SPLIT_NONE;
    end else if (reg_wr && reg_addr == TFS_ADDR_TX_LEN_HI) begin
      ntx_q[9:5] <= reg_wdata[4:0];
    end else if (reg_wr && reg_addr == TFS_ADDR_TX_LEN_LO) begin
      ntx_q[4:0] <= reg_wdata[7:3];
      nbtx_q     <= reg_wdata[2:0];
    end
  end

  // Framer view; split bits only honoured in level-3 bit-stream mode
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_bytes_q      <= 10'h000;
      tx_split_bits_q <= TFS_SPLIT_NONE;
    end else begin
      tx_bytes_q      <= ntx_q;
      tx_split_bits_q <= (level3_mode && bit_stream_tx) ? nbtx_q : TFS_SPLIT_NONE;
    end
  end

  // Registered read data, one cycle after the read strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= TFS_RST_REG;
    end else if (reg_rd) begin
      case (reg_addr)
        TFS_ADDR_AUX_IRQ:   reg_rdata_q <= aux_q;
        TFS_ADDR_FIFO_CNT:  reg_rdata_q <= {2'b00, unread_q};
        TFS_ADDR_FIFO_ERR:  reg_rdata_q <= {1'b0, unf_q, ovr_q, ncp_q, lbits_q, npar_q};
        TFS_ADDR_TX_LEN_HI: reg_rdata_q <= {3'b000, ntx_q[9:5]};
        TFS_ADDR_TX_LEN_LO: reg_rdata_q <= {ntx_q[4:0], nbtx_q};
        default:            reg_rdata_q <= TFS_RST_REG;
      endcase
    end
  end

endmodule

/* File: verification/testbench.sv */
// Register sequence bench for the FIFO status block
module testbench
  import tfs_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, arst_n = 0, reg_wr, reg_rd, cmd_set_default = 0, cmd_fifo_clear = 0;
  logic fifo_push = 0, fifo_pop = 0, rx_last_partial = 0, rx_parity_missing = 0;
  logic aux_other_set_en = 0, level3_mode = 0, bit_stream_tx = 0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, aux_other_set = 8'h00, v;
  logic [2:0] rx_last_bits = 3'h0, tx_split_bits_q;
  logic [9:0] tx_bytes_q;
  int miscompares = 0, checked = 0;
  always #2 clk_sys = ~clk_sys;
  tfs_top tfs_top_inst (.*);
  tfs_host tfs_host_inst (.*);
  task automatic tick;
    @(posedge clk_sys);
  endtask
  task automatic cmp(input string n, input logic [9:0] e, s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [7:0] a, e);
    tfs_host_inst.rd(a, v);
    cmp($sformatf("reg %h", a), {2'b0, e}, {2'b0, v});
  endtask
  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5) tick;
    arst_n <= 1;
    tick;
    rc(TFS_ADDR_FIFO_ERR, 8'h00);
    rc(TFS_ADDR_TX_LEN_LO, 8'h00);
    tfs_host_inst.wr(TFS_ADDR_TX_LEN_HI, 8'hFF);
    tfs_host_inst.wr(TFS_ADDR_TX_LEN_LO, 8'hAD);
    tfs_host_inst.wr(TFS_ADDR_FIFO_CNT, 8'hFF);
    rc(TFS_ADDR_TX_LEN_HI, 8'h1F);
    rc(TFS_ADDR_TX_LEN_LO, 8'hAD);
    rc(8'h3F, 8'h00);
    cmp("bytes", 10'h3F5, tx_bytes_q);
    // Split bits only pass with both mode bits set
    {level3_mode, bit_stream_tx} <= 2'b11;
    repeat (3) tick;
    cmp("split", 10'h005, {7'h0, tx_split_bits_q});
    level3_mode <= 0;
    repeat (3) tick;
    cmp("split", 10'h000, {7'h0, tx_split_bits_q});
    // One push past full, last byte short and without parity
    fifo_push <= 1;
    repeat (32) tick;
    {rx_last_partial, rx_last_bits, rx_parity_missing} <= 5'h1B;
    tick;
    fifo_push <= 0;
    rc(TFS_ADDR_FIFO_CNT, 8'h20);
    rc(TFS_ADDR_FIFO_ERR, 8'h3B);
    rc(TFS_ADDR_AUX_IRQ, 8'h48);
    rc(TFS_ADDR_AUX_IRQ, 8'h00);
    cmd_fifo_clear <= 1;
    tick;
    cmd_fifo_clear <= 0;
    rc(TFS_ADDR_FIFO_ERR, 8'h00);
    // Clear, then at once a pop on empty plus another aux event
    cmd_fifo_clear <= 1;
    tick;
    {cmd_fifo_clear, fifo_pop, aux_other_set_en, aux_other_set} <= 11'h380;
    tick;
    {fifo_pop, aux_other_set_en} <= 2'b00;
    rc(TFS_ADDR_FIFO_ERR, 8'h40);
    rc(TFS_ADDR_AUX_IRQ, 8'h88);
    fifo_pop <= 1;
    tick;
    {fifo_pop, cmd_set_default} <= 2'b01;
    tick;
    cmd_set_default <= 0;
    rc(TFS_ADDR_AUX_IRQ, 8'h00);
    cmp("bytes", 10'h000, tx_bytes_q);
    close_out();
  end
endmodule

/* File: verification/tfs_host.sv */
// Host controller model on the register port
module tfs_host (
  // Register port
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata_q,
  output logic            reg_wr, reg_rd,
  output logic      [7:0] reg_addr, reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // Released lines show the inverse, not a stale value
  task automatic wr(input logic [7:0] a, d);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
    @(posedge clk_sys);
  endtask
  // Data lands on the edge that takes the strobe and is sampled one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    {reg_rd, reg_addr} <= {1'b0, ~a};
    @(posedge clk_sys);
    d = reg_rdata_q;
  endtask
endmodule

/* File: verification/tfs_monitor.sv */
// Port checker for the FIFO status and transmit length block
module tfs_monitor
  import tfs_pkg::*;
(
  // Observed ports
  input wire logic       clk_sys, arst_n, reg_wr, reg_rd, cmd_set_default, cmd_fifo_clear,
  input wire logic       fifo_push, fifo_pop, aux_other_set_en, level3_mode, bit_stream_tx,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata_q,
  input wire logic [9:0] tx_bytes_q,
  input wire logic [2:0] tx_split_bits_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // No event source may set flags this cycle
  wire logic quiet = !fifo_push && !fifo_pop && !aux_other_set_en;
  wire logic ra = reg_rd && reg_addr == TFS_ADDR_AUX_IRQ;
  AST_AUX_CLR: assert property (ra && quiet ##1 quiet ##1 ra |=> reg_rdata_q == 8'h00)
    else $error("aux not cleared");
  AST_SET_DEF: assert property (cmd_set_default && !reg_wr |-> ##2 tx_bytes_q == 10'h000)
    else $error("count not cleared");
  AST_CNT_MAX: assert property (reg_rd && reg_addr == TFS_ADDR_FIFO_CNT |=> reg_rdata_q <= 8'h20)
    else $error("count out of range");
  AST_RSV: assert property (reg_rd && reg_addr == TFS_ADDR_FIFO_ERR |=> !reg_rdata_q[7])
    else $error("reserved bit set");
  AST_UNF: assert property (cmd_fifo_clear && quiet ##1 fifo_pop && !fifo_push ##1
    reg_rd && reg_addr == TFS_ADDR_FIFO_ERR |=> reg_rdata_q[TFS_BIT_UNF])
    else $error("no underflow");
  AST_AUX_FIFO: assert property (cmd_fifo_clear && quiet ##1 fifo_pop && !fifo_push ##1
    !ra && !cmd_set_default ##1 !ra && !cmd_set_default ##1 ra
    |=> reg_rdata_q[TFS_BIT_AUX_FIFO])
    else $error("no fifo error");
  AST_SPLIT: assert property (!(level3_mode && bit_stream_tx) [*2] |-> tx_split_bits_q == 3'h0)
    else $error("split bits leak");
  AST_TX_HI: assert property (reg_wr && reg_addr == TFS_ADDR_TX_LEN_HI && !cmd_set_default
    ##1 !reg_wr && !cmd_set_default |=> tx_bytes_q[9:5] == $past(reg_wdata[4:0], 2))
    else $error("high count wrong");
endmodule
bind tfs_top tfs_monitor tfs_monitor_inst (.*);
